// file: cal_info_pkg.sv
package cal_info_pkg;

    // information page geometry
    localparam int unsigned PAGE_BYTES = 128;
    localparam int unsigned PAGE_AW    = 7;

    // page locations of the factory bytes
    localparam logic [6:0] IDX_SERIAL_BYTE3   = 7'h1c;
    localparam logic [6:0] IDX_SERIAL_BYTE2   = 7'h1d;
    localparam logic [6:0] IDX_SERIAL_BYTE1   = 7'h1e;
    localparam logic [6:0] IDX_SERIAL_BYTE0   = 7'h1f;
    localparam logic [6:0] IDX_TEMP_CAL_HIGH  = 7'h3a;
    localparam logic [6:0] IDX_TEMP_CAL_LOW   = 7'h3b;
    localparam logic [6:0] IDX_WDOG_CAL_HIGH  = 7'h7e;
    localparam logic [6:0] IDX_WDOG_CAL_LOW   = 7'h7f;

    // block registers beyond the page, as word indexes
    localparam logic [7:0] IDX_CTRL   = 8'h80;
    localparam logic [7:0] IDX_STATUS = 8'h81;

    // control and status fields
    localparam logic [7:0] CTRL_RESET      = 8'h00;
    localparam int unsigned CTRL_WR_EN_BIT = 0;
    localparam int unsigned STAT_ERR_BIT   = 0;
    localparam int unsigned STAT_WREN_BIT  = 1;
    localparam int unsigned STAT_CNT_LSB   = 8;

    // processor window: memory address = base plus page offset
    localparam logic [8:0] WINDOW_BASE_HI = 9'h1fc;

    // value software puts in the upper reload byte
    localparam logic [7:0] WDOG_UPPER_VAL = 8'h00;

    typedef logic [PAGE_BYTES-1:0][7:0] page_t;

    typedef struct packed {
        logic [31:0] serial_number;
        logic [11:0] temp_offset_cal;
        logic [7:0]  wdog_reload_upper;
        logic [7:0]  wdog_reload_high;
        logic [7:0]  wdog_reload_low;
    } cal_values_t;

    // word index lies inside the information page
    function automatic logic page_hit(input logic [7:0] idx);
        return idx[7] == 1'b0;
    endfunction

    // memory address falls in the information page window
    function automatic logic window_hit(input logic [15:0] addr);
        return addr[15:7] == WINDOW_BASE_HI;
    endfunction

endpackage

// file: info_page_array.sv
module info_page_array
    import cal_info_pkg::*;
(
    // clock
    input  wire logic               clk,
    // write port
    input  wire logic               wr_en,
    input  wire logic [PAGE_AW-1:0] wr_idx,
    input  wire logic [7:0]         wr_data,
    // whole page, held in flops
    output page_t                   page
);

    logic [7:0] mem [PAGE_BYTES];

    // no reset: contents survive every reset
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    always_comb begin
        for (int i = 0; i < PAGE_BYTES; i++) begin
            page[i] = mem[i];
        end
    end

endmodule // info_page_array

// file: page_window.sv
module page_window
    import cal_info_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // processor byte read
    input  wire logic        rd_en,
    input  wire logic [15:0] rd_addr,
    output logic      [7:0]  rd_data,
    output logic             rd_valid,
    output logic             rd_hit,
    // page contents
    input  wire page_t       page
);

    logic [7:0] data_reg;
    logic [7:0] data_next;
    logic       valid_reg;
    logic       valid_next;
    logic       hit_reg;
    logic       hit_next;

    // pure read, the page is never touched here
    always_comb begin
        valid_next = rd_en;
        hit_next   = rd_en & window_hit(rd_addr);
        data_next  = data_reg;
        if (rd_en) begin
            // byte at base plus offset
            data_next = window_hit(rd_addr)
                      ? page[rd_addr[PAGE_AW-1:0]] : 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_reg  <= 8'h00;
            valid_reg <= 1'b0;
            hit_reg   <= 1'b0;
        end else begin
            data_reg  <= data_next;
            valid_reg <= valid_next;
            hit_reg   <= hit_next;
        end
    end

    assign rd_data  = data_reg;
    assign rd_valid = valid_reg;
    assign rd_hit   = hit_reg;

endmodule // page_window

// file: calibration_info_page.sv
// Summary of operation
// - the 12-bit temperature offset is the low nibble of the high byte joined to the low byte.
// - temperature high byte sits at page offset 3a, low byte at 3b.
// - no reset clears a stored calibration or serial byte; reset zeroes the cal_values copy and the prdata and cpu_rd_data read registers.
// - watchdog calibration high byte sits at 7e, low byte at 7f.
// - those reload bytes give the watchdog a one second timeout.
// - a four-byte serial number sits at page offsets 1c to 1f.
// - serial bytes run most significant first, memory address fe00+offset.
//
// Implementation choice: register access over APB.
module calibration_info_page
    import cal_info_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,

    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,

    // processor byte window
    input  wire logic        cpu_rd_en,
    input  wire logic [15:0] cpu_addr,
    output logic      [7:0]  cpu_rd_data,
    output logic             cpu_rd_valid,
    output logic             cpu_rd_hit,

    // calibration values for the sensor and watchdog
    output cal_values_t      cal_values
);

    typedef enum logic [0:0] {
        ST_IDLE   = 1'b0,
        ST_ACCESS = 1'b1
    } apb_state_t;

    // bus state
    apb_state_t  state_reg;
    apb_state_t  state_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        err_reg;
    logic        err_next;

    // control and status
    logic [7:0]  ctrl_reg;
    logic [7:0]  ctrl_next;
    logic [7:0]  wr_count_reg;
    logic [7:0]  wr_count_next;
    logic        last_err_reg;
    logic        last_err_next;

    // calibration outputs
    cal_values_t cal_reg;
    cal_values_t cal_next;

    // page
    page_t       page;
    logic        page_wr;

    // decode of the current address
    logic [7:0]  idx;
    logic        setup;
    logic        access;
    logic        aligned;
    logic        in_page;
    logic        is_ctrl;
    logic        is_status;
    logic        mapped;
    logic        wr_allowed;
    logic        setup_err;
    logic [31:0] status_word;
    logic        do_write;

    assign idx     = paddr[9:2];
    assign setup   = psel & ~penable;
    assign access  = psel & penable;
    assign aligned = (paddr[1:0] == 2'b00) & (paddr[11:10] == 2'b00);

    assign in_page   = aligned & page_hit(idx);
    assign is_ctrl   = aligned & (idx == IDX_CTRL);
    assign is_status = aligned & (idx == IDX_STATUS);
    assign mapped    = in_page | is_ctrl | is_status;

    // page bytes take writes only while software has opened them
    assign wr_allowed = is_ctrl
                      | (in_page & ctrl_reg[CTRL_WR_EN_BIT]);

    always_comb begin
        setup_err = ~mapped;
        if (pwrite && !wr_allowed) begin
            setup_err = 1'b1;
        end
    end

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[STAT_ERR_BIT]  = last_err_reg;
        status_word[STAT_WREN_BIT] = ctrl_reg[CTRL_WR_EN_BIT];
        status_word[STAT_CNT_LSB +: 8] = wr_count_reg;
    end

    // the write lands on the access edge, and only there
    assign do_write = access & pwrite & ~err_reg;
    assign page_wr  = do_write & in_page & pstrb[0];

    // ----- bus handshake -----
    always_comb begin
        state_next = state_reg;
        rdata_next = rdata_reg;
        err_next   = err_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (setup) begin
                    state_next = ST_ACCESS;
                    err_next   = setup_err;
                    rdata_next = 32'h0000_0000;
                    if (!pwrite && in_page) begin
                        // read leaves the byte as it is
                        rdata_next = {24'h00_0000, page[idx[6:0]]};
                    end else if (!pwrite && is_ctrl) begin
                        rdata_next = {24'h00_0000, ctrl_reg};
                    end else if (!pwrite && is_status) begin
                        rdata_next = status_word;
                    end
                end
            end
            ST_ACCESS: begin
                // zero wait states: the access ends on its first edge
                state_next = ST_IDLE;
                if (!access) begin
                    err_next = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            rdata_reg <= 32'h0000_0000;
            err_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            rdata_reg <= rdata_next;
            err_reg   <= err_next;
        end
    end

    assign prdata  = rdata_reg;
    assign pready  = access;
    assign pslverr = access & err_reg;

    // ----- control and status -----
    always_comb begin
        ctrl_next     = ctrl_reg;
        wr_count_next = wr_count_reg;
        last_err_next = last_err_reg;
        if (access) begin
            last_err_next = err_reg;
        end
        if (do_write && is_ctrl && pstrb[0]) begin
            ctrl_next = pwdata[7:0];
        end
        if (page_wr) begin
            wr_count_next = wr_count_reg + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg     <= CTRL_RESET;
            wr_count_reg <= 8'h00;
            last_err_reg <= 1'b0;
        end else begin
            ctrl_reg     <= ctrl_next;
            wr_count_reg <= wr_count_next;
            last_err_reg <= last_err_next;
        end
    end

    // ----- calibration values -----
    always_comb begin
        cal_next = cal_reg;
        // most significant byte at the lowest offset
        cal_next.serial_number = {
            page[IDX_SERIAL_BYTE3],
            page[IDX_SERIAL_BYTE2],
            page[IDX_SERIAL_BYTE1],
            page[IDX_SERIAL_BYTE0]
        };
        // low nibble of the high byte over the low byte
        cal_next.temp_offset_cal = {
            page[IDX_TEMP_CAL_HIGH][3:0],
            page[IDX_TEMP_CAL_LOW]
        };
        // reload triple for a one second timeout
        cal_next.wdog_reload_upper = WDOG_UPPER_VAL;
        cal_next.wdog_reload_high  = page[IDX_WDOG_CAL_HIGH];
        cal_next.wdog_reload_low   = page[IDX_WDOG_CAL_LOW];
    end

    // output copy only; the page itself never sees the reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_reg <= '0;
        end else begin
            cal_reg <= cal_next;
        end
    end

    assign cal_values = cal_reg;

    // ----- storage and processor window -----
    info_page_array u_array (
        .clk     (pclk),
        .wr_en   (page_wr),
        .wr_idx  (idx[6:0]),
        .wr_data (pwdata[7:0]),
        .page    (page)
    );

    page_window u_window (
        .clk      (pclk),
        .rst_n    (presetn),
        .rd_en    (cpu_rd_en),
        .rd_addr  (cpu_addr),
        .rd_data  (cpu_rd_data),
        .rd_valid (cpu_rd_valid),
        .rd_hit   (cpu_rd_hit),
        .page     (page)
    );

endmodule // calibration_info_page

// file: cal_info_checker.sv
module cal_info_checker
    import cal_info_pkg::*;
(
    // apb side
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    // byte window and values
    input wire logic        cpu_rd_en,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0]  cpu_rd_data,
    input wire logic        cpu_rd_valid,
    input wire logic        cpu_rd_hit,
    input wire cal_values_t cal_values
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    rdy_zero_wait_a: assert property (pready == (psel && penable))
        else $error("pready not tied to access phase");
    err_in_access_a: assert property (pslverr |-> pready)
        else $error("pslverr outside access phase");
    bad_addr_a: assert property (psel && penable &&
        (paddr[9:2] > 8'h81 || paddr[1:0] != 2'h0) |-> pslverr)
        else $error("bad address not refused");
    rd_valid_a: assert property (cpu_rd_valid == $past(cpu_rd_en))
        else $error("read valid not one cycle after request");
    window_hit_a: assert property (cpu_rd_valid |->
        cpu_rd_hit == ($past(cpu_addr[15:7]) == 9'h1fc))
        else $error("window decode wrong");
    miss_zero_a: assert property (cpu_rd_valid && !cpu_rd_hit |->
        cpu_rd_data == 8'h00)
        else $error("miss data not zero");
    data_hold_a: assert property (!$past(cpu_rd_en) |-> $stable(cpu_rd_data))
        else $error("read data moved without request");
    upper_zero_a: assert property (cal_values.wdog_reload_upper == 8'h00)
        else $error("upper reload byte not zero");
    serial_msb_a: assert property (cpu_rd_valid &&
        $past(cpu_addr) == 16'hfe1c |->
        cpu_rd_data == cal_values.serial_number[31:24])
        else $error("serial msb mismatch");
    wdog_high_a: assert property (cpu_rd_valid &&
        $past(cpu_addr) == 16'hfe7e |->
        cpu_rd_data == cal_values.wdog_reload_high)
        else $error("watchdog high mismatch");
    temp_high_a: assert property (cpu_rd_valid &&
        $past(cpu_addr) == 16'hfe3a |->
        cpu_rd_data[3:0] == cal_values.temp_offset_cal[11:8])
        else $error("temperature high nibble mismatch");
    temp_low_a: assert property (cpu_rd_valid &&
        $past(cpu_addr) == 16'hfe3b |->
        cpu_rd_data == cal_values.temp_offset_cal[7:0])
        else $error("temperature low byte mismatch");
    serial_lsb_a: assert property (cpu_rd_valid &&
        $past(cpu_addr) == 16'hfe1f |->
        cpu_rd_data == cal_values.serial_number[7:0])
        else $error("serial lsb mismatch");
    wdog_low_a: assert property (cpu_rd_valid &&
        $past(cpu_addr) == 16'hfe7f |->
        cpu_rd_data == cal_values.wdog_reload_low)
        else $error("watchdog low mismatch");

    hit_c: cover property (cpu_rd_valid && cpu_rd_hit);
    err_c: cover property (pslverr);
    miss_c: cover property (cpu_rd_valid && !cpu_rd_hit);
endmodule // cal_info_checker

bind calibration_info_page cal_info_checker i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .cpu_rd_en(cpu_rd_en), .cpu_addr(cpu_addr), .cpu_rd_data(cpu_rd_data),
    .cpu_rd_valid(cpu_rd_valid), .cpu_rd_hit(cpu_rd_hit),
    .cal_values(cal_values)
);

// file: test_calibration_info_page.sv
module test_calibration_info_page
    import cal_info_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk, presetn, psel, penable, pwrite, cpu_rd_en;
    logic        pready, pslverr, cpu_rd_valid, cpu_rd_hit, x;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  pstrb;
    logic [15:0] cpu_addr;
    logic [7:0]  cpu_rd_data;
    cal_values_t cal;
    int          err_count, compares;

    typedef struct packed { logic [6:0] idx; logic [7:0] val; } row_t;
    row_t rows [8] = '{'{7'h1c, 8'ha1}, '{7'h1d, 8'hb2}, '{7'h1e, 8'hc3},
                       '{7'h1f, 8'hd4}, '{7'h3a, 8'he5}, '{7'h3b, 8'h96},
                       '{7'h7e, 8'h37}, '{7'h7f, 8'h48}};

    calibration_info_page i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_rd_en(cpu_rd_en), .cpu_addr(cpu_addr),
        .cpu_rd_data(cpu_rd_data), .cpu_rd_valid(cpu_rd_valid),
        .cpu_rd_hit(cpu_rd_hit), .cal_values(cal)
    );

    always #5 pclk = ~pclk;

    task automatic conclude();
        if (err_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            err_count++;
        r = prdata;
        x = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic e);
        apb(1'b1, a, d);
        chk({31'h0, x}, {31'h0, e});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d,
                      input logic e);
        apb(1'b0, a, 32'h0);
        chk({31'h0, x}, {31'h0, e});
        if (!e)
            chk(r, d);
    endtask

    task automatic cr(input logic [15:0] a, input logic h,
                      input logic [7:0] d);
        @(posedge pclk);
        cpu_rd_en <= 1'b1;
        cpu_addr  <= a;
        @(posedge pclk);
        cpu_rd_en <= 1'b0;
        #1;
        chk({31'h0, cpu_rd_valid}, 32'h1);
        chk({31'h0, cpu_rd_hit}, {31'h0, h});
        chk({24'h0, cpu_rd_data}, {24'h0, d});
    endtask

    // reads every row by bus and window, then the derived values
    task automatic check_rows();
        foreach (rows[i]) begin
            rd({3'h0, rows[i].idx, 2'h0}, {24'h0, rows[i].val}, 1'b0);
            cr({9'h1fc, rows[i].idx}, 1'b1, rows[i].val);
        end
        repeat (2) @(posedge pclk);
        chk(cal.serial_number, 32'ha1b2c3d4);
        chk({20'h0, cal.temp_offset_cal}, 32'h596);
        chk({8'h0, cal.wdog_reload_upper, cal.wdog_reload_high,
             cal.wdog_reload_low}, 32'h003748);
    endtask

    initial begin
        #100us;
        err_count++;
        conclude();
    end

    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; pstrb = 4'hf; cpu_rd_en = 0; cpu_addr = 0;
        err_count = 0; compares = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h200, 32'h0, 1'b0);
        wr(12'h070, 32'h55, 1'b1);
        wr(12'h200, 32'h1, 1'b0);
        foreach (rows[i])
            wr({3'h0, rows[i].idx, 2'h0}, {24'h0, rows[i].val}, 1'b0);
        rd(12'h204, 32'h0000_0802, 1'b0);
        check_rows();
        pstrb <= 4'he;
        wr(12'h1f8, 32'h99, 1'b0);
        pstrb <= 4'hf;
        rd(12'h208, 32'h0, 1'b1);
        rd(12'h071, 32'h0, 1'b1);
        rd(12'hc70, 32'h0, 1'b1);
        rd(12'h204, 32'h0000_0803, 1'b0);
        wr(12'h204, 32'h1, 1'b1);
        cr(16'hfe80, 1'b0, 8'h00);
        cr(16'hfdff, 1'b0, 8'h00);
        wr(12'h200, 32'h0, 1'b0);
        wr(12'h1f8, 32'h99, 1'b1);
        cr(16'hfe7e, 1'b1, 8'h37);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(cal.serial_number, 32'h0);
        chk(prdata, 32'h0);
        presetn <= 1'b1;
        rd(12'h200, 32'h0, 1'b0);
        rd(12'h204, 32'h0, 1'b0);
        check_rows();
        conclude();
    end
endmodule // test_calibration_info_page
